// File: bench/cspix_card_model.sv
// Card-side sink that takes posted words off both sockets' card bus
module cspix_card_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [1:0]  stall_i,
  input  wire logic        slow_i,
  input  wire logic [1:0]  valid_i,
  input  wire logic [63:0] data_i,
  output logic [1:0]       ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rx_a[$];
  logic [31:0] rx_b[$];
  logic        phase_reg;

  // Slow mode answers every other cycle, a stall never answers
  assign ready_o = ~stall_i & {2{~slow_i | phase_reg}};

  // Each word is taken whole, all 32 bits at once
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
      if (valid_i[0] && ready_o[0]) rx_a.push_back(data_i[31:0]);
      if (valid_i[1] && ready_o[1]) rx_b.push_back(data_i[63:32]);
    end
  end
endmodule : cspix_card_model

// File: bench/cspix_top_chk.sv
// Port-level concurrent checks for the socket power and index block
module cspix_top_chk
  import cspix_pkg::*;
(
  input wire logic                   MCLK_I,
  input wire logic                   RST_N_I,
  input wire logic [1:0]             REG_ADDR_I,
  input wire cspix_pkg::cspix_byte_t REG_WDATA_I,
  input wire logic                   REG_WR_I,
  input wire logic                   REG_RD_I,
  input wire logic [7:0]             REG_RDATA_O,
  input wire logic [1:0]             CARD_WR_READY_O,
  input wire logic [1:0]             CARD_BUS_VALID_O,
  input wire logic [63:0]            CARD_BUS_DATA_O,
  input wire logic [1:0]             CARD_BUS_READY_I,
  input wire logic [1:0]             CARD_DETECT_ONE_N_I,
  input wire logic [1:0]             CARD_DETECT_TWO_N_I,
  input wire logic [1:0]             VCC_EN_O,
  input wire logic [1:0]             VPP_EN_O,
  input wire logic                   IRQ_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  // Five cycles covers the two-stage sync plus presence and enable flops
  a_vcc_off_a: assert property ((CARD_DETECT_ONE_N_I[0] || CARD_DETECT_TWO_N_I[0])[*5]
    |=> !VCC_EN_O[0] && !VPP_EN_O[0]) else $error("socket A powered with no card");
  a_vcc_off_b: assert property ((CARD_DETECT_ONE_N_I[1] || CARD_DETECT_TWO_N_I[1])[*5]
    |=> !VCC_EN_O[1] && !VPP_EN_O[1]) else $error("socket B powered with no card");
  a_vpp_needs_vcc: assert property ((VPP_EN_O & ~VCC_EN_O) == 2'b00)
    else $error("programming supply on without main supply");
  a_vcc_rise_cause: assert property ($rose(VCC_EN_O[0]) |->
    !$past(CARD_DETECT_ONE_N_I[0], 3) && !$past(CARD_DETECT_TWO_N_I[0], 3))
    else $error("main supply rose without both detect pins low");
  a_rdata_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 8'h00)
    else $error("read data not zero outside read answer cycle");
  a_bus_word_hold: assert property (CARD_BUS_VALID_O[0] && !CARD_BUS_READY_I[0]
    |=> CARD_BUS_VALID_O[0] && $stable(CARD_BUS_DATA_O[31:0]))
    else $error("card bus word changed while stalled");
  a_ready_after_reset: assert property ($rose(RST_N_I) |-> ##[1:3] CARD_WR_READY_O == 2'b11)
    else $error("write buffers not ready after reset");
  a_mask_off_irq: assert property ((REG_WR_I && REG_ADDR_I == 2'h3 && REG_WDATA_I == 8'h00)
    ##1 !(REG_WR_I && REG_ADDR_I == 2'h3) |=> !IRQ_O)
    else $error("interrupt stayed high with all sources masked");
endmodule : cspix_top_chk

bind cspix_top cspix_top_chk cspix_top_chk_inst (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .CARD_WR_READY_O(CARD_WR_READY_O),
  .CARD_BUS_VALID_O(CARD_BUS_VALID_O), .CARD_BUS_DATA_O(CARD_BUS_DATA_O),
  .CARD_BUS_READY_I(CARD_BUS_READY_I), .CARD_DETECT_ONE_N_I(CARD_DETECT_ONE_N_I),
  .CARD_DETECT_TWO_N_I(CARD_DETECT_TWO_N_I), .VCC_EN_O(VCC_EN_O), .VPP_EN_O(VPP_EN_O),
  .IRQ_O(IRQ_O));

// File: bench/cspix_top_tb.sv
// Self-checking bench for socket power, card-detect interrupt and index access
module cspix_top_tb;
  import cspix_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst_n, reg_wr, reg_rd, irq, slow;
  logic [1:0]  reg_addr, wr_valid, wr_ready, bus_valid, bus_ready, bus_tset;
  logic [1:0]  cd1_n, cd2_n, vs1, vs2, vcc_en, vpp_en, stall;
  cspix_byte_t reg_wdata;
  logic [7:0]  rdata, d;
  logic [63:0] wr_data, bus_data;
  int          error_cnt, tests_run, n, k;

  // Free-running 100 MHz clock
  always #5 mclk = ~mclk;

  cspix_top cspix_top_inst (.MCLK_I(mclk), .RST_N_I(rst_n), .CE_I(1'b1),
    .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
    .REG_RDATA_O(rdata), .CARD_WR_VALID_I(wr_valid), .CARD_WR_DATA_I(wr_data),
    .CARD_WR_READY_O(wr_ready), .CARD_BUS_VALID_O(bus_valid), .CARD_BUS_DATA_O(bus_data),
    .CARD_BUS_TSET_O(bus_tset), .CARD_BUS_READY_I(bus_ready),
    .CARD_DETECT_ONE_N_I(cd1_n), .CARD_DETECT_TWO_N_I(cd2_n),
    .VOLTAGE_SENSE_ONE_I(vs1), .VOLTAGE_SENSE_TWO_I(vs2),
    .VCC_EN_O(vcc_en), .VPP_EN_O(vpp_en), .IRQ_O(irq));
  cspix_card_model cspix_card_model_inst (.clk_i(mclk), .rst_n_i(rst_n), .stall_i(stall),
    .slow_i(slow), .valid_i(bus_valid), .data_i(bus_data), .ready_o(bus_ready));

  // ----------------------------------------------------------------
  // Compare, bus and pin tasks
  // ----------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : chk_word
  // Settled sampling point: land on the falling edge after the count
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
    @(negedge mclk);
  endtask : cyc
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask : rd
  task automatic ixw(input logic [7:0] i, input logic [7:0] v);
    wr(2'h0, i);
    wr(2'h1, v);
  endtask : ixw
  task automatic ixr(input logic [7:0] i, input logic [7:0] e);
    wr(2'h0, i);
    rd(2'h1);
    chk_byte(d, e);
  endtask : ixr
  // Both detect pins move together; low means a card sits in the slot
  task automatic card(input int s, input logic p);
    @(posedge mclk);
    cd1_n[s] <= ~p; cd2_n[s] <= ~p;
    cyc(8);
  endtask : card
  task automatic results;
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 0; rst_n = 0; reg_wr = 0; reg_rd = 0; reg_addr = 2'h0; reg_wdata = 8'h00;
    wr_valid = 2'h0; wr_data = 64'h0; cd1_n = 2'h3; cd2_n = 2'h3; vs1 = 2'h0; vs2 = 2'h0;
    stall = 2'h0; slow = 0; error_cnt = 0; tests_run = 0; n = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    cyc(3);
    chk_byte({4'h0, vcc_en, vpp_en}, 8'h00);
    ixr(8'h02, 8'h00);
    ixr(8'h42, 8'h00);
    $display("Test reset values done");
    ixw(8'h02, 8'h31);
    ixw(8'h42, 8'h10);
    ixw(8'h20, 8'h5a);
    ixr(8'h02, 8'h31);
    ixr(8'h42, 8'h10);
    rd(2'h1);
    chk_byte(d, 8'h10);
    ixr(8'h20, 8'h00);
    ixw(8'h3a, 8'h5c);
    ixr(8'h3a, 8'h5c);
    ixr(8'h3d, 8'h00);
    $display("Test index access done");
    wr(2'h3, 8'h0f);
    ixw(8'h05, 8'h08);
    ixw(8'h45, 8'h08);
    card(0, 1'b1);
    card(1, 1'b1);
    chk_byte({4'h0, vcc_en, vpp_en}, 8'h05);
    chk_byte({7'h0, irq}, 8'h01);
    rd(2'h2);
    chk_byte(d, 8'h05);
    wr(2'h2, 8'h05);
    cyc(3);
    chk_byte({7'h0, irq}, 8'h00);
    ixw(8'h42, 8'h30);
    cyc(3);
    chk_byte({6'h0, vcc_en}, 8'h03);
    ixr(8'h41, 8'h03);
    $display("Test insertion done");
    card(0, 1'b0);
    chk_byte({4'h0, vcc_en, vpp_en}, 8'h08);
    rd(2'h2);
    chk_byte(d, 8'h02);
    ixr(8'h02, 8'h21);
    wr(2'h3, 8'h00);
    cyc(3);
    chk_byte({7'h0, irq}, 8'h00);
    wr(2'h2, 8'h0f);
    wr(2'h3, 8'h0f);
    ixw(8'h2e, 8'h03);
    ixw(8'h2f, 8'h02);
    ixr(8'h2f, 8'h02);
    ixw(8'h02, 8'h31);
    card(0, 1'b1);
    card(0, 1'b0);
    ixr(8'h02, 8'h31);
    $display("Test removal done");
    @(posedge mclk);
    vs1 <= 2'b01; vs2 <= 2'b10;
    cyc(4);
    ixw(8'h2e, 8'h0a);
    ixr(8'h6f, 8'h09);
    $display("Test voltage sense done");
    ixw(8'h07, 8'h01);
    @(posedge mclk);
    stall <= 2'b01; slow <= 1'b1;
    // The ready flag lags, so each push waits two cycles before the next look
    for (k = 0; k < 8 && wr_ready[0]; k++) begin
      @(posedge mclk);
      wr_valid <= 2'b11; wr_data <= {32'hbeef_0000 + k, 32'hc0de_0000 + k};
      @(posedge mclk);
      wr_valid <= 2'b00;
      n++;
      cyc(2);
    end
    chk_byte({7'h0, n inside {4, 5}}, 8'h01);
    chk_byte({6'h0, wr_ready}, 8'h02);
    // Socket B word still waits here for its every-other-cycle ready
    chk_byte({4'h0, bus_tset, bus_valid}, 8'h07);
    @(posedge mclk);
    stall <= 2'b00;
    for (k = 0; k < 60 && cspix_card_model_inst.rx_a.size() < n; k++) cyc(1);
    chk_byte(8'(cspix_card_model_inst.rx_a.size()), 8'(n));
    for (k = 0; k < cspix_card_model_inst.rx_a.size(); k++)
      chk_word(cspix_card_model_inst.rx_a[k], 32'hc0de_0000 + k);
    chk_word(cspix_card_model_inst.rx_b[0], 32'hbeef_0000);
    ixr(8'h08, 8'h01);
    ixw(8'h07, 8'h00);
    $display("Test write buffers done");
    results();
  end
endmodule : cspix_top_tb

// File: rtl/cspix_fifo_if.sv
// Push/pop bundle between the top and one write buffer
interface cspix_fifo_if #(parameter int WIDTH = 32);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;
  logic             empty;

  modport owner (output push_valid, output push_data, input push_ready,
                 input pop_valid, input pop_data, output pop_ready, input empty);
  modport fifo  (input push_valid, input push_data, output push_ready,
                 output pop_valid, output pop_data, input pop_ready, output empty);
endinterface : cspix_fifo_if

// File: rtl/cspix_params.svh
// Register indices, field positions, reset values and sizes for the socket/index block
`ifndef CSPIX_PARAMS_SVH
`define CSPIX_PARAMS_SVH

// ----------------------------------------------------------------
// Host I/O port addresses (byte offsets from the block base)
// ----------------------------------------------------------------
`define CSPIX_ADDR_INDEX       2'h0
`define CSPIX_ADDR_DATA        2'h1
`define CSPIX_ADDR_IRQ_STATUS  2'h2
`define CSPIX_ADDR_IRQ_MASK    2'h3

// ----------------------------------------------------------------
// Internal register indices (per-socket ones are socket A; socket B adds the offset)
// ----------------------------------------------------------------
`define CSPIX_SOCKET_B_OFFSET  8'h40
`define CSPIX_IDX_CSC_ENABLE   8'h05
`define CSPIX_IDX_POWER_CTRL   8'h02
`define CSPIX_IDX_CARD_STATUS  8'h01
`define CSPIX_IDX_WINDOW_TIMER 8'h07
`define CSPIX_IDX_FIFO_STATUS  8'h08
`define CSPIX_IDX_TIMER_SET0   8'h3a
`define CSPIX_IDX_TIMER_SET1   8'h3d
`define CSPIX_IDX_EXT_INDEX    8'h2e
`define CSPIX_IDX_EXT_DATA     8'h2f
`define CSPIX_XIDX_EXT_CTRL1   8'h03
`define CSPIX_XIDX_EXT_DATA_VS 8'h0a
`define CSPIX_IDX_VS_HOME      8'h6f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSPIX_PWR_VPP_EN_BIT   0
`define CSPIX_PWR_AUTO_BIT     4
`define CSPIX_PWR_VCC_EN_BIT   5
`define CSPIX_XC1_KEEP_AUTO    1
`define CSPIX_CSC_CD_EN_BIT    3

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define CSPIX_RESET_BYTE       8'h00
`define CSPIX_FIFO_DEPTH       4
`define CSPIX_WORD_WIDTH       32

`endif

// File: rtl/cspix_pkg.sv
// Types shared by the socket/index block files
package cspix_pkg;
  // Socket card-detect tracking
  typedef enum logic [1:0] {
    CSPIX_EMPTY   = 2'b00,
    CSPIX_PRESENT = 2'b01
  } cspix_card_t;

  // Byte type for the register write data
  typedef logic [7:0] cspix_byte_t;
endpackage : cspix_pkg

// File: rtl/cspix_top.sv
// Dual-socket power, card-detect interrupt and indexed register access
`include "cspix_params.svh"
module cspix_top
  import cspix_pkg::*;
#(
  parameter int FIFO_DEPTH = `CSPIX_FIFO_DEPTH,
  parameter int WORD_WIDTH = `CSPIX_WORD_WIDTH
) (
  input  wire logic                  MCLK_I,
  input  wire logic                  RST_N_I,
  input  wire logic                  CE_I,
  // Register port
  input  wire logic [1:0]            REG_ADDR_I,
  input  wire cspix_pkg::cspix_byte_t REG_WDATA_I,
  input  wire logic                  REG_WR_I,
  input  wire logic                  REG_RD_I,
  output logic [7:0]                 REG_RDATA_O,
  // Host card-write port, one per socket
  input  wire logic [1:0]            CARD_WR_VALID_I,
  input  wire logic [63:0]           CARD_WR_DATA_I,
  output logic [1:0]                 CARD_WR_READY_O,
  // Card side draining of the buffers
  output logic [1:0]                 CARD_BUS_VALID_O,
  output logic [63:0]                CARD_BUS_DATA_O,
  output logic [1:0]                 CARD_BUS_TSET_O,
  input  wire logic [1:0]            CARD_BUS_READY_I,
  // Socket pins, index 0 is socket A
  input  wire logic [1:0]            CARD_DETECT_ONE_N_I,
  input  wire logic [1:0]            CARD_DETECT_TWO_N_I,
  input  wire logic [1:0]            VOLTAGE_SENSE_ONE_I,
  input  wire logic [1:0]            VOLTAGE_SENSE_TWO_I,
  output logic [1:0]                 VCC_EN_O,
  output logic [1:0]                 VPP_EN_O,
  output logic                       IRQ_O
);
  import cspix_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] index_reg;
  logic [7:0] ext_index_reg;
  logic [7:0] ext_ctrl1_reg;
  logic [7:0] timer_set_reg [2];
  logic [7:0] pwr_ctrl_reg [2];
  logic [7:0] csc_en_reg [2];
  logic [7:0] win_tsel_reg [2];
  logic [3:0] irq_status_reg;
  logic [3:0] irq_mask_reg;
  logic [7:0] rdata_reg;
  logic       irq_reg;
  logic [1:0] vcc_reg;
  logic [1:0] vpp_reg;
  logic [1:0] present_reg;
  logic [1:0] cd1_meta_reg;
  logic [1:0] cd1_sync_reg;
  logic [1:0] cd2_meta_reg;
  logic [1:0] cd2_sync_reg;
  logic [3:0] vs_meta_reg;
  logic [3:0] vs_sync_reg;
  logic [1:0] bus_valid_reg;
  logic [63:0] bus_data_reg;
  logic [1:0] bus_tset_reg;
  logic [1:0] wr_ready_reg;
  logic [1:0] fifo_empty;
  logic [3:0] irq_status_next;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two stages so a metastable card pin cannot reach the decode
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cd1_meta_reg <= 2'h3;
      cd1_sync_reg <= 2'h3;
      cd2_meta_reg <= 2'h3;
      cd2_sync_reg <= 2'h3;
      vs_meta_reg  <= 4'h0;
      vs_sync_reg  <= 4'h0;
    end else if (CE_I) begin
      cd1_meta_reg <= CARD_DETECT_ONE_N_I;
      cd1_sync_reg <= cd1_meta_reg;
      cd2_meta_reg <= CARD_DETECT_TWO_N_I;
      cd2_sync_reg <= cd2_meta_reg;
      vs_meta_reg  <= {VOLTAGE_SENSE_TWO_I, VOLTAGE_SENSE_ONE_I};
      vs_sync_reg  <= vs_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire        wr_index   = REG_WR_I & (REG_ADDR_I == `CSPIX_ADDR_INDEX);
  wire        wr_data    = REG_WR_I & (REG_ADDR_I == `CSPIX_ADDR_DATA);
  wire        wr_status  = REG_WR_I & (REG_ADDR_I == `CSPIX_ADDR_IRQ_STATUS);
  wire        wr_mask    = REG_WR_I & (REG_ADDR_I == `CSPIX_ADDR_IRQ_MASK);
  wire        sock_b     = index_reg[6];
  wire [7:0]  base_idx   = index_reg & 8'hbf;
  wire        hit_xidx   = (index_reg == `CSPIX_IDX_EXT_INDEX);
  wire        hit_xdata  = (index_reg == `CSPIX_IDX_EXT_DATA);
  wire        hit_vshome = (index_reg == `CSPIX_IDX_VS_HOME);
  wire        hit_xc1    = hit_xdata & (ext_index_reg == `CSPIX_XIDX_EXT_CTRL1);
  wire        hit_vs     = hit_vshome & (ext_index_reg == `CSPIX_XIDX_EXT_DATA_VS);
  wire        hit_pwr    = (base_idx == `CSPIX_IDX_POWER_CTRL);
  wire        hit_csc    = (base_idx == `CSPIX_IDX_CSC_ENABLE);
  wire        hit_stat   = (base_idx == `CSPIX_IDX_CARD_STATUS);
  wire        hit_wtsel  = (base_idx == `CSPIX_IDX_WINDOW_TIMER);
  wire        hit_fstat  = (base_idx == `CSPIX_IDX_FIFO_STATUS);
  wire        hit_ts0    = (index_reg == `CSPIX_IDX_TIMER_SET0);
  wire        hit_ts1    = (index_reg == `CSPIX_IDX_TIMER_SET1);
  wire        keep_auto  = ext_ctrl1_reg[`CSPIX_XC1_KEEP_AUTO];

  // ----------------------------------------------------------------
  // Card detect events per socket
  // ----------------------------------------------------------------
  wire [1:0] present_now = ~cd1_sync_reg & ~cd2_sync_reg;
  wire [1:0] inserted    = present_now & ~present_reg;
  wire [1:0] removed     = ~present_now & present_reg;

  // Index data readback mux
  logic [7:0] data_mux;
  always_comb begin
    data_mux = 8'h00;
    if (hit_xidx) begin
      data_mux = ext_index_reg;
    end else if (hit_xc1) begin
      data_mux = ext_ctrl1_reg;
    end else if (hit_vs) begin
      data_mux = {4'h0, vs_sync_reg};
    end else if (hit_ts0) begin
      data_mux = timer_set_reg[0];
    end else if (hit_ts1) begin
      data_mux = timer_set_reg[1];
    end else if (hit_pwr) begin
      data_mux = pwr_ctrl_reg[sock_b];
    end else if (hit_csc) begin
      data_mux = csc_en_reg[sock_b];
    end else if (hit_wtsel) begin
      data_mux = win_tsel_reg[sock_b];
    end else if (hit_stat) begin
      data_mux = {6'h00, present_reg[sock_b], fifo_empty[sock_b]};
    end else if (hit_fstat) begin
      data_mux = {7'h00, fifo_empty[sock_b]};
    end
  end

  // Port level readback mux
  wire [7:0] port_mux = (REG_ADDR_I == `CSPIX_ADDR_INDEX)      ? index_reg :
                        (REG_ADDR_I == `CSPIX_ADDR_DATA)       ? data_mux :
                        (REG_ADDR_I == `CSPIX_ADDR_IRQ_STATUS) ? {4'h0, irq_status_reg} :
                                                                 {4'h0, irq_mask_reg};

  // ----------------------------------------------------------------
  // Index, extension and timing registers
  // ----------------------------------------------------------------
  // Index persists until the host writes it again
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      index_reg        <= `CSPIX_RESET_BYTE;
      ext_index_reg    <= `CSPIX_RESET_BYTE;
      ext_ctrl1_reg    <= `CSPIX_RESET_BYTE;
      timer_set_reg[0] <= `CSPIX_RESET_BYTE;
      timer_set_reg[1] <= `CSPIX_RESET_BYTE;
      irq_mask_reg     <= 4'h0;
    end else if (CE_I) begin
      if (wr_index) index_reg <= REG_WDATA_I;
      if (wr_mask) irq_mask_reg <= REG_WDATA_I[3:0];
      if (wr_data && hit_xidx) ext_index_reg <= REG_WDATA_I;
      if (wr_data && hit_xc1) ext_ctrl1_reg <= REG_WDATA_I;
      if (wr_data && hit_ts0) timer_set_reg[0] <= REG_WDATA_I;
      if (wr_data && hit_ts1) timer_set_reg[1] <= REG_WDATA_I;
    end
  end

  // ----------------------------------------------------------------
  // Per-socket power, enables and buffers
  // ----------------------------------------------------------------
  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_sock
      cspix_fifo_if #(.WIDTH(WORD_WIDTH)) fif ();
      wire sel = (sock_b == 1'(s));
      wire vcc_next;
      wire vpp_next;

      // Host side always pushes whole words, never narrower lanes
      assign fif.push_valid = CARD_WR_VALID_I[s];
      assign fif.push_data  = CARD_WR_DATA_I[s*32 +: 32];
      assign fif.pop_ready  = ~bus_valid_reg[s] | CARD_BUS_READY_I[s];
      assign fifo_empty[s]  = fif.empty;

      cspix_wfifo #(
        .DEPTH (FIFO_DEPTH),
        .WIDTH (WORD_WIDTH)
      ) u_wfifo (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .ce_i    (CE_I),
        .port    (fif)
      );

      // Supply enables follow power control only while a card sits
      assign vcc_next = present_reg[s] & pwr_ctrl_reg[s][`CSPIX_PWR_AUTO_BIT]
                        & pwr_ctrl_reg[s][`CSPIX_PWR_VCC_EN_BIT];
      assign vpp_next = vcc_next & pwr_ctrl_reg[s][`CSPIX_PWR_VPP_EN_BIT];

      // Power control: removal clears auto bit unless kept
      always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          pwr_ctrl_reg[s] <= `CSPIX_RESET_BYTE;
          csc_en_reg[s]   <= `CSPIX_RESET_BYTE;
          win_tsel_reg[s] <= `CSPIX_RESET_BYTE;
        end else if (CE_I) begin
          if (wr_data && hit_pwr && sel) begin
            pwr_ctrl_reg[s] <= REG_WDATA_I;
          end else if (removed[s] && !keep_auto) begin
            pwr_ctrl_reg[s][`CSPIX_PWR_AUTO_BIT] <= 1'b0;
          end
          if (wr_data && hit_csc && sel) csc_en_reg[s] <= REG_WDATA_I;
          if (wr_data && hit_wtsel && sel) win_tsel_reg[s] <= REG_WDATA_I;
        end
      end

      // Outputs: supplies drop in the cycle after removal is seen
      always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          vcc_reg[s]       <= 1'b0;
          vpp_reg[s]       <= 1'b0;
          present_reg[s]   <= 1'b0;
          bus_valid_reg[s] <= 1'b0;
          bus_data_reg[s*32 +: 32] <= 32'h0000_0000;
          bus_tset_reg[s]  <= 1'b0;
          wr_ready_reg[s]  <= 1'b0;
        end else if (CE_I) begin
          present_reg[s] <= present_now[s];
          vcc_reg[s]     <= vcc_next & present_now[s];
          vpp_reg[s]     <= vpp_next & present_now[s];
          wr_ready_reg[s] <= fif.push_ready;
          if (fif.pop_ready) begin
            bus_valid_reg[s]         <= fif.pop_valid;
            bus_data_reg[s*32 +: 32] <= fif.pop_data;
            bus_tset_reg[s]          <= win_tsel_reg[s][0];
          end
        end
      end

      // Insert and remove events share one enable bit
      assign irq_status_next[2*s]   = irq_status_reg[2*s] & ~(wr_status & REG_WDATA_I[2*s])
                                      | (inserted[s] & csc_en_reg[s][`CSPIX_CSC_CD_EN_BIT]);
      assign irq_status_next[2*s+1] = irq_status_reg[2*s+1] & ~(wr_status & REG_WDATA_I[2*s+1])
                                      | (removed[s] & csc_en_reg[s][`CSPIX_CSC_CD_EN_BIT]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt status, readback and outputs
  // ----------------------------------------------------------------
  // Set beats write-one-to-clear in the same cycle
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_status_reg <= 4'h0;
      irq_reg        <= 1'b0;
      rdata_reg      <= 8'h00;
    end else if (CE_I) begin
      irq_status_reg <= irq_status_next;
      irq_reg        <= |(irq_status_next & irq_mask_reg);
      rdata_reg      <= REG_RD_I ? port_mux : 8'h00;
    end
  end

  assign REG_RDATA_O      = rdata_reg;
  assign IRQ_O            = irq_reg;
  assign VCC_EN_O         = vcc_reg;
  assign VPP_EN_O         = vpp_reg;
  assign CARD_WR_READY_O  = wr_ready_reg;
  assign CARD_BUS_VALID_O = bus_valid_reg;
  assign CARD_BUS_DATA_O  = bus_data_reg;
  assign CARD_BUS_TSET_O  = bus_tset_reg;
endmodule : cspix_top

// File: rtl/cspix_wfifo.sv
// Four-word posted write buffer for one socket
`include "cspix_params.svh"
module cspix_wfifo #(
  parameter int DEPTH = `CSPIX_FIFO_DEPTH,
  parameter int WIDTH = `CSPIX_WORD_WIDTH
) (
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  input  wire logic   ce_i,
  cspix_fifo_if.fifo  port
);
  import cspix_pkg::*;
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              do_push;
  wire              do_pop;

  // ----------------------------------------------------------------
  // Handshake decode
  // ----------------------------------------------------------------
  assign port.push_ready = (count_reg != (AW+1)'(DEPTH));
  assign port.pop_valid  = (count_reg != '0);
  assign port.pop_data   = mem_reg[rd_ptr_reg];
  assign port.empty      = (count_reg == '0);
  assign do_push         = ce_i & port.push_valid & port.push_ready;
  assign do_pop          = ce_i & port.pop_valid & port.pop_ready;

  // Storage array has no reset; the word at the read pointer is driven out and taken by the top even when the buffer is empty
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= port.push_data;
    end
  end

  // Pointers wrap; depth must be a power of two
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (do_push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (do_pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end
  end
endmodule : cspix_wfifo
